// ===== core/civc_map.svh
// Command opcodes, field positions and reset values of the interrupt controller.
`ifndef CIVC_MAP_SVH
`define CIVC_MAP_SVH
`define OP_MSB         7
`define OP_LSB         5
`define OP_RESET       3'h0
`define OP_PEND        3'h1
`define OP_SERV        3'h2
`define OP_MASK        3'h3
`define OP_MODE_LO     3'h4
`define OP_MODE_HI     3'h5
`define OP_DATA_SEL    3'h6
`define OP_RESP_SEL    3'h7
`define CMD_ALL_BIT    4
`define CMD_SET_BIT    3
`define CMD_HI_SEL_MSB 4
`define CMD_HI_SEL_LSB 3
`define HI_SEL_BIT5    2'h0
`define HI_SEL_BIT6    2'h1
`define HI_SEL_BIT7    2'h2
`define MODE_COMMON    1
`define MODE_POLLED    2
`define MODE_GRP_HIGH  3
`define MODE_RISE_EDGE 4
`define MODE_MMASK     7
`define STAT_VALID     3
`define STAT_MODE0     4
`define STAT_MODE2     5
`define STAT_MODE7     6
`define STAT_GRP       7
`define RDSEL_SERV     2'h0
`define RDSEL_MASK     2'h1
`define RDSEL_PEND     2'h2
`define RDSEL_ACR      2'h3
`define MASK_RESET     8'hFF
`define BYTE_ZERO      8'h00
`endif

// ===== core/civc_pkg.sv
// Types shared by the interrupt controller and its users.
package civc_pkg;
	typedef enum logic [0:0] {
		RESP_IDLE = 1'b0,
		RESP_SEND = 1'b1
	} resp_state_t;
	typedef enum logic [1:0] {
		WT_MASK = 2'b00,
		WT_AUTO = 2'b01,
		WT_RESP = 2'b10
	} write_target_t;
	typedef struct packed {
		logic cs_n;
		logic rd_n;
		logic wr_n;
		logic cd;
		logic ack_n;
	} host_ctrl_t;
endpackage : civc_pkg

// ===== core/cascadable_vectored_interrupt_controller.sv
// Eight-input cascadable vectored interrupt controller with host bus and response memory.
// Behaviour
// - Data bus is driven only during a read or an owned acknowledge byte.
// - Reads and writes need chip select low; acknowledges ignore chip select.
// - Control writes load the command, control reads return status then clear it.
// - Each request input is taken on a programmable edge with fixed own priority.
// - The owning controller holds response-in-process low until its response ends.
// - A non-owning controller ignores acknowledges while response-in-process is low.
// - One to four acknowledge pulses are taken, one response byte each.
// - First acknowledge picks the best unmasked pending request and pulls response-in-process low.
// - Pause goes low on the first acknowledge until response-in-process goes low.
// - Enable-out stays low while a request is valid, busy, or master mask set.
// - Enable-in low makes the controller ignore acknowledge pulses.
// - Group interrupt shows any eligible unmasked pending request except in polled mode, polarity programmable.
// - Pending bits set by edge or software, cleared by software, acknowledge, reset.
// - Acknowledge sets in-service and clears pending; in-service masks lower priorities.
// - Auto-clear bits clear in-service at the end of the response; reset clears them.
// - Mask bits load, set or clear all or singly; reset sets all; pending kept.
// - A 32-byte response memory holds four bytes per input, sent on acknowledge.
// - Status bit 7 ignores polarity; the vector field is latched with a status read.
// - One command loads mode bits 0 to 4; bits 5, 6, 7 each have their own.
// - Mode is not readable, but mode bits 0, 2 and 7 appear in status.
// - The command register keeps the last command, which acts or preselects data.
// - Each input has a 2-bit byte count; response-in-process stays low until reached.
// - Reset clears all registers but sets mask; memory and byte counts are kept.
// - Data reads return the register chosen by mode bits 5 and 6 only.
`timescale 1ns/10ps
`include "civc_map.svh"
module cascadable_vectored_interrupt_controller #(
	parameter int NUM_INPUTS      = 8,
	parameter int BYTES_PER_INPUT = 4
) (
	// Clock and reset.
	input  wire logic                clk_sys,
	input  wire logic                reset_n,
	// Host bus.
	input  wire civc_pkg::host_ctrl_t host_ctrl,
	input  wire logic [7:0]          host_data_bus_in,
	output logic      [7:0]          host_data_bus_out,
	output logic                     host_data_bus_oe,
	// Request inputs.
	input  wire logic [7:0]          request_inputs,
	// Daisy chain.
	input  wire logic                chain_enable_in,
	output logic                     chain_enable_out,
	// Open-drain response-in-process line.
	input  wire logic                response_in_process_in,
	output logic                     response_in_process_out,
	output logic                     response_in_process_oe,
	// Open-drain pause line.
	output logic                     pause_out,
	output logic                     pause_oe,
	// Group interrupt.
	output logic                     group_interrupt_out,
	output logic                     group_interrupt_oe
);
	import civc_pkg::*;

	localparam int SYNC_W = 23;
	localparam int MEM_W  = NUM_INPUTS * BYTES_PER_INPUT;

	logic [SYNC_W-1:0] sync1_r;
	logic [SYNC_W-1:0] sync2_r;
	logic [7:0]        req_s;
	logic [7:0]        req_d_r;
	logic [7:0]        req_edge;
	logic [7:0]        data_s;
	host_ctrl_t        ctl_s;
	logic              en_in_s;
	logic              line_free_s;
	logic              rd_act;
	logic              rd_act_r;
	logic              wr_act;
	logic              wr_act_r;
	logic              ack_d_r;
	logic              ack_fall;
	logic              ack_rise;
	logic              rd_start;
	logic              rd_end;
	logic              wr_end;
	logic [7:0]        wr_data_r;
	logic              wr_cd_r;
	logic              cmd_wr;
	logic              data_wr;
	logic [2:0]        opcode;
	logic              reset_cmd;
	logic [7:0]        pending_request_r;
	logic [7:0]        in_service_r;
	logic [7:0]        request_mask_r;
	logic [7:0]        auto_clear_select_r;
	logic [7:0]        operating_options_r;
	logic [7:0]        last_command_r;
	logic [7:0]        chip_status_r;
	logic [7:0]        live_status;
	logic [7:0]        read_mux;
	logic [1:0]        response_length_r [NUM_INPUTS];
	logic [7:0]        resp_mem_r [MEM_W];
	write_target_t     target_r;
	logic [2:0]        load_level_r;
	logic [1:0]        load_ptr_r;
	resp_state_t       state_r;
	logic [2:0]        sel_r;
	logic [1:0]        byte_r;
	logic              cand_valid;
	logic [2:0]        cand_idx;
	logic              take;
	logic              finish;
	logic              group_live;
	logic [2:0]        mem_base;
	logic [4:0]        mem_addr;
	logic [7:0]        bit_sel;

	// Every pin input passes two flip-flops; the first stage feeds only the second.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			// Request stages reset low, like the edge history, so no false edge follows reset.
			sync1_r <= 23'h007FFF;
			sync2_r <= 23'h007FFF;
		end else begin
			sync1_r <= {request_inputs, host_data_bus_in, host_ctrl,
				chain_enable_in, response_in_process_in};
			sync2_r <= sync1_r;
		end
	end

	assign req_s  = sync2_r[22:15];
	assign data_s = sync2_r[14:7];
	assign ctl_s  = sync2_r[6:2];
	assign en_in_s     = sync2_r[1];
	assign line_free_s = sync2_r[0];

	// Edge detection per input; the polarity bit picks rising or falling.
	genvar g;
	generate
		for (g = 0; g < 8; g++) begin : g_edge
			assign req_edge[g] = operating_options_r[`MODE_RISE_EDGE] ?
				(req_s[g] & ~req_d_r[g]) : (~req_s[g] & req_d_r[g]);
		end
	endgenerate

	// Strobe history for edge detection on the synchronised host controls.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			req_d_r  <= `BYTE_ZERO;
			rd_act_r <= 1'b0;
			wr_act_r <= 1'b0;
			ack_d_r  <= 1'b1;
		end else begin
			req_d_r  <= req_s;
			rd_act_r <= rd_act;
			wr_act_r <= wr_act;
			ack_d_r  <= ctl_s.ack_n;
		end
	end

	// Chip select conditions reads and writes, never the acknowledge.
	assign rd_act    = ~ctl_s.cs_n & ~ctl_s.rd_n;
	assign wr_act    = ~ctl_s.cs_n & ~ctl_s.wr_n;
	assign rd_start  = rd_act & ~rd_act_r;
	assign rd_end    = ~rd_act & rd_act_r;
	assign wr_end    = ~wr_act & wr_act_r;
	assign ack_fall  = ~ctl_s.ack_n & ack_d_r;
	assign ack_rise  = ctl_s.ack_n & ~ack_d_r;

	// Write data is caught while the strobe is low, because hold time may be zero.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			wr_data_r <= `BYTE_ZERO;
			wr_cd_r   <= 1'b0;
		end else if (wr_act) begin
			wr_data_r <= data_s;
			wr_cd_r   <= ctl_s.cd;
		end
	end

	// The write takes effect on the trailing edge of the strobe.
	assign cmd_wr    = wr_end & wr_cd_r;
	assign data_wr   = wr_end & ~wr_cd_r;
	assign opcode    = wr_data_r[`OP_MSB:`OP_LSB];
	assign reset_cmd = cmd_wr & (opcode == `OP_RESET);
	assign bit_sel   = wr_data_r[`CMD_ALL_BIT] ? 8'hFF : (8'h01 << wr_data_r[2:0]);

	// Fixed priority: input 0 highest; an in-service bit blocks itself and below.
	always_comb begin
		logic blk;
		blk        = 1'b0;
		cand_valid = 1'b0;
		cand_idx   = 3'h0;
		for (int i = 0; i < 8; i++) begin
			blk = blk | in_service_r[i];
			if (!cand_valid && !blk && pending_request_r[i] && !request_mask_r[i]) begin
				cand_valid = 1'b1;
				cand_idx   = 3'(i);
			end
		end
	end

	// Acknowledge is taken only with enable-in high and the shared line free.
	assign take = (state_r == RESP_IDLE) & ack_fall & en_in_s & line_free_s & cand_valid
		& ~operating_options_r[`MODE_MMASK];
	assign finish = (state_r == RESP_SEND) & ack_rise
		& (byte_r == response_length_r[sel_r]);

	// Pending requests: edges set, and a set in the same cycle beats any clear but the reset command.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			pending_request_r <= `BYTE_ZERO;
		end else if (reset_cmd) begin
			pending_request_r <= `BYTE_ZERO;
		end else begin
			logic [7:0] nxt;
			nxt = pending_request_r;
			if (cmd_wr && opcode == `OP_PEND) begin
				nxt = wr_data_r[`CMD_SET_BIT] ? (nxt | bit_sel) : (nxt & ~bit_sel);
			end
			if (take) begin
				nxt[cand_idx] = 1'b0;
			end
			pending_request_r <= nxt | req_edge;
		end
	end

	// In-service bits: set by acknowledge, cleared by software or auto-clear.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			in_service_r <= `BYTE_ZERO;
		end else if (reset_cmd) begin
			in_service_r <= `BYTE_ZERO;
		end else begin
			logic [7:0] nxt;
			nxt = in_service_r;
			if (cmd_wr && opcode == `OP_SERV) begin
				nxt = wr_data_r[`CMD_SET_BIT] ? (nxt | bit_sel) : (nxt & ~bit_sel);
			end
			if (finish && auto_clear_select_r[sel_r]) begin
				nxt[sel_r] = 1'b0;
			end
			if (take) begin
				nxt[cand_idx] = 1'b1;
			end
			in_service_r <= nxt;
		end
	end

	// Mask bits: whole-byte load by data write, set or clear by command.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			request_mask_r <= `MASK_RESET;
		end else if (reset_cmd) begin
			request_mask_r <= `MASK_RESET;
		end else if (cmd_wr && opcode == `OP_MASK) begin
			request_mask_r <= wr_data_r[`CMD_SET_BIT] ?
				(request_mask_r | bit_sel) : (request_mask_r & ~bit_sel);
		end else if (data_wr && target_r == WT_MASK) begin
			request_mask_r <= wr_data_r;
		end
	end

	// Auto-clear selection, loaded by data write after its preselect.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			auto_clear_select_r <= `BYTE_ZERO;
		end else if (reset_cmd) begin
			auto_clear_select_r <= `BYTE_ZERO;
		end else if (data_wr && target_r == WT_AUTO) begin
			auto_clear_select_r <= wr_data_r;
		end
	end

	// Mode: low five bits in one command, the upper three one at a time.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			operating_options_r <= `BYTE_ZERO;
		end else if (reset_cmd) begin
			operating_options_r <= `BYTE_ZERO;
		end else if (cmd_wr && opcode == `OP_MODE_LO) begin
			operating_options_r[4:0] <= wr_data_r[4:0];
		end else if (cmd_wr && opcode == `OP_MODE_HI) begin
			case (wr_data_r[`CMD_HI_SEL_MSB:`CMD_HI_SEL_LSB])
				`HI_SEL_BIT5: operating_options_r[5] <= wr_data_r[0];
				`HI_SEL_BIT6: operating_options_r[6] <= wr_data_r[0];
				`HI_SEL_BIT7: operating_options_r[7] <= wr_data_r[0];
				default: operating_options_r <= operating_options_r;
			endcase
		end
	end

	// Last command and the data-write target that it preselects.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			last_command_r <= `BYTE_ZERO;
			target_r       <= WT_MASK;
			load_level_r   <= 3'h0;
			load_ptr_r     <= 2'h0;
		end else if (reset_cmd) begin
			last_command_r <= `BYTE_ZERO;
			target_r       <= WT_MASK;
			load_level_r   <= 3'h0;
			load_ptr_r     <= 2'h0;
		end else if (cmd_wr) begin
			last_command_r <= wr_data_r;
			if (opcode == `OP_DATA_SEL) begin
				target_r <= wr_data_r[0] ? WT_AUTO : WT_MASK;
			end else if (opcode == `OP_RESP_SEL) begin
				target_r     <= WT_RESP;
				load_level_r <= wr_data_r[2:0];
				load_ptr_r   <= 2'h0;
			end
		end else if (data_wr && target_r == WT_RESP) begin
			load_ptr_r <= load_ptr_r + 2'h1;
		end
	end

	// Response memory and byte counts keep their contents through any reset.
	always_ff @(posedge clk_sys) begin
		if (cmd_wr && opcode == `OP_RESP_SEL) begin
			response_length_r[wr_data_r[2:0]] <= wr_data_r[4:3];
		end
		if (data_wr && target_r == WT_RESP) begin
			resp_mem_r[{load_level_r, load_ptr_r}] <= wr_data_r;
		end
	end

	// Acknowledge sequence: one byte per pulse until the programmed count.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			state_r <= RESP_IDLE;
			sel_r   <= 3'h0;
			byte_r  <= 2'h0;
		end else begin
			case (state_r)
				RESP_IDLE: begin
					if (take) begin
						state_r <= RESP_SEND;
						sel_r   <= cand_idx;
						byte_r  <= 2'h0;
					end
				end
				RESP_SEND: begin
					if (reset_cmd || finish) begin
						state_r <= RESP_IDLE;
					end else if (ack_rise) begin
						byte_r <= byte_r + 2'h1;
					end
				end
				default: state_r <= RESP_IDLE;
			endcase
		end
	end

	// Common vector mode always answers with the first input's bytes.
	assign mem_base = operating_options_r[`MODE_COMMON] ? 3'h0 : sel_r;
	assign mem_addr = {mem_base, byte_r};

	// Group interrupt is suppressed in polled mode and by the master mask.
	assign group_live = cand_valid & ~operating_options_r[`MODE_POLLED]
		& ~operating_options_r[`MODE_MMASK];

	// Live status; the vector field is the best candidate at the moment of reading.
	always_comb begin
		live_status                = `BYTE_ZERO;
		live_status[2:0]           = cand_idx;
		live_status[`STAT_VALID]   = cand_valid;
		live_status[`STAT_MODE0]   = operating_options_r[0];
		live_status[`STAT_MODE2]   = operating_options_r[2];
		live_status[`STAT_MODE7]   = operating_options_r[7];
		live_status[`STAT_GRP]     = cand_valid & ~operating_options_r[`MODE_MMASK];
	end

	// Data reads use the preselect in mode bits 5 and 6; memory is not reachable here.
	always_comb begin
		case (operating_options_r[6:5])
			`RDSEL_SERV: read_mux = in_service_r;
			`RDSEL_MASK: read_mux = request_mask_r;
			`RDSEL_PEND: read_mux = pending_request_r;
			`RDSEL_ACR: read_mux = auto_clear_select_r;
			default:    read_mux = `BYTE_ZERO;
		endcase
	end

	// Status is frozen at the start of a control read and cleared when it ends.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			chip_status_r <= `BYTE_ZERO;
		end else if (rd_start && ctl_s.cd) begin
			chip_status_r <= live_status;
		end else if (rd_end || reset_cmd) begin
			chip_status_r <= `BYTE_ZERO;
		end
	end

	// Data bus drive: a read, or an owned acknowledge pulse, never otherwise.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			host_data_bus_out <= `BYTE_ZERO;
			host_data_bus_oe  <= 1'b0;
		end else begin
			host_data_bus_oe <= rd_act | ((state_r == RESP_SEND) & ~ctl_s.ack_n);
			if (state_r == RESP_SEND) begin
				host_data_bus_out <= resp_mem_r[mem_addr];
			end else if (rd_start) begin
				host_data_bus_out <= ctl_s.cd ? live_status : read_mux;
			end else if (rd_act_r && ctl_s.cd) begin
				host_data_bus_out <= chip_status_r;
			end
		end
	end

	// Open-drain lines and the chain output.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			response_in_process_out <= 1'b0;
			response_in_process_oe  <= 1'b0;
			pause_out               <= 1'b0;
			pause_oe                <= 1'b0;
			chain_enable_out        <= 1'b0;
			group_interrupt_out     <= 1'b0;
			group_interrupt_oe      <= 1'b0;
		end else begin
			response_in_process_out <= 1'b0;
			// The line is pulled at the very edge that takes the acknowledge, with pause.
			response_in_process_oe  <= (take | ((state_r == RESP_SEND) & ~finish))
				& ~reset_cmd;
			pause_out               <= 1'b0;
			// Pause lasts until the line is seen driven, so later bytes never lower it.
			pause_oe                <= take | (pause_oe & ~response_in_process_oe);
			chain_enable_out        <= en_in_s & ~operating_options_r[`MODE_MMASK]
				& (state_r == RESP_IDLE) & ~cand_valid & ~take;
			if (operating_options_r[`MODE_GRP_HIGH]) begin
				group_interrupt_out <= group_live;
				group_interrupt_oe  <= 1'b1;
			end else begin
				group_interrupt_out <= 1'b0;
				group_interrupt_oe  <= group_live;
			end
		end
	end
endmodule : cascadable_vectored_interrupt_controller

// ===== bench/civc_checker_asserts.sv
// Concurrent pin checks for the cascadable vectored interrupt controller.
`timescale 1ns/10ps
module civc_checker_asserts (
	// Clock and reset.
	input wire logic                 clk_sys,
	input wire logic                 reset_n,
	// Host bus.
	input wire civc_pkg::host_ctrl_t host_ctrl,
	input wire logic [7:0]           host_data_bus_in,
	input wire logic [7:0]           host_data_bus_out,
	input wire logic                 host_data_bus_oe,
	// Requests and daisy chain.
	input wire logic [7:0]           request_inputs,
	input wire logic                 chain_enable_in,
	input wire logic                 chain_enable_out,
	// Open-drain and interrupt lines.
	input wire logic                 response_in_process_in,
	input wire logic                 response_in_process_out,
	input wire logic                 response_in_process_oe,
	input wire logic                 pause_out,
	input wire logic                 pause_oe,
	input wire logic                 group_interrupt_out,
	input wire logic                 group_interrupt_oe
);
	import civc_pkg::*;
	logic [5:0] strobe_hist_r;
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	// Keeps six cycles of read or acknowledge strobes, since the bus lags its pins.
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			strobe_hist_r <= 6'h00;
		end else begin
			strobe_hist_r <= {strobe_hist_r[4:0],
				!host_ctrl.ack_n || (!host_ctrl.cs_n && !host_ctrl.rd_n)};
		end
	end
	a_bus_only_read: assert property (host_data_bus_oe |-> strobe_hist_r != 6'h00)
		else $error("data bus driven without read or acknowledge");
	a_pause_one_cycle: assert property (pause_oe
		|-> $rose(response_in_process_oe) ##1 !pause_oe)
		else $error("pause not a single pulse at response start");
	a_open_drain_low: assert property (!response_in_process_out && !pause_out)
		else $error("open-drain line driven high");
	a_resp_ends_quiet: assert property ($fell(response_in_process_oe)
		|-> $past(host_ctrl.ack_n) && $past(host_ctrl.ack_n, 2))
		else $error("response line released during acknowledge");
	a_ack_needs_line: assert property ($rose(response_in_process_oe)
		|-> $past(chain_enable_in) && $past(response_in_process_in))
		else $error("acknowledge taken while disabled or line busy");
	a_chain_low_busy: assert property (response_in_process_oe
		&& $past(response_in_process_oe) |-> !chain_enable_out)
		else $error("enable out high during own response");
	a_chain_needs_en: assert property (!chain_enable_in [*4] |-> !chain_enable_out)
		else $error("enable out high while enable in low");
	a_group_drive_form: assert property (group_interrupt_out |-> group_interrupt_oe)
		else $error("group interrupt high without drive");
endmodule : civc_checker_asserts
bind cascadable_vectored_interrupt_controller civc_checker_asserts i_civc_checker_asserts (
	.clk_sys(clk_sys), .reset_n(reset_n), .host_ctrl(host_ctrl),
	.host_data_bus_in(host_data_bus_in), .host_data_bus_out(host_data_bus_out),
	.host_data_bus_oe(host_data_bus_oe), .request_inputs(request_inputs),
	.chain_enable_in(chain_enable_in), .chain_enable_out(chain_enable_out),
	.response_in_process_in(response_in_process_in),
	.response_in_process_out(response_in_process_out),
	.response_in_process_oe(response_in_process_oe), .pause_out(pause_out),
	.pause_oe(pause_oe), .group_interrupt_out(group_interrupt_out),
	.group_interrupt_oe(group_interrupt_oe));

// ===== bench/civc_far_side.sv
// Far-side model: host data bus wire, pulled-up lines and the pull of a second cascaded controller.
`timescale 1ns/10ps
module civc_far_side (
	// Clock.
	input  wire logic       clk_sys,
	// Drivers of the data bus.
	input  wire logic [7:0] host_data,
	input  wire logic       host_den,
	input  wire logic [7:0] dev_data,
	input  wire logic       dev_oe,
	// Pull-downs on the open-drain lines.
	input  wire logic       resp_oe,
	input  wire logic       pause_oe,
	input  wire logic       other_busy,
	// Resolved wires.
	output logic [7:0]      bus,
	output logic            resp_line,
	output logic            pause_line
);
	logic [7:0] last_r = 8'h00;
	// A released bus keeps no value; it shows the inverse of the last one so stale reads fail.
	always_comb begin
		if (host_den) begin
			bus = host_data;
		end else if (dev_oe) begin
			bus = dev_data;
		end else begin
			bus = ~last_r;
		end
	end
	// Remembers the last driven byte only, so a released bus shows one steady inverse.
	always @(posedge clk_sys) begin
		if (host_den || dev_oe) begin
			last_r <= bus;
		end
	end
	// Pull-ups; the other controller pulls the response line while it answers.
	assign resp_line  = !(resp_oe || other_busy);
	assign pause_line = !pause_oe;
endmodule : civc_far_side

// ===== bench/cascadable_vectored_interrupt_controller_tb_top.sv
// Self-checking testbench of the interrupt controller through its host bus.
`timescale 1ns/10ps
module cascadable_vectored_interrupt_controller_tb_top;
	import civc_pkg::*;
	logic       clk_sys, reset_n, host_den, dev_oe, chain_enable_in, chain_enable_out;
	logic       other_busy, cs_val, resp_line, resp_oe, pause_line, pause_oe, grp_out, grp_oe;
	logic [7:0] host_data, bus, dev_data, request_inputs;
	host_ctrl_t host_ctrl;
	int         fails, num_checks;
	cascadable_vectored_interrupt_controller i_cascadable_vectored_interrupt_controller (
		.clk_sys(clk_sys), .reset_n(reset_n), .host_ctrl(host_ctrl),
		.host_data_bus_in(bus), .host_data_bus_out(dev_data), .host_data_bus_oe(dev_oe),
		.request_inputs(request_inputs), .chain_enable_in(chain_enable_in),
		.chain_enable_out(chain_enable_out), .response_in_process_in(resp_line),
		.response_in_process_out(), .response_in_process_oe(resp_oe), .pause_out(),
		.pause_oe(pause_oe), .group_interrupt_out(grp_out), .group_interrupt_oe(grp_oe));
	civc_far_side i_civc_far_side (.clk_sys(clk_sys), .host_data(host_data),
		.host_den(host_den), .dev_data(dev_data), .dev_oe(dev_oe), .resp_oe(resp_oe),
		.pause_oe(pause_oe), .other_busy(other_busy), .bus(bus), .resp_line(resp_line),
		.pause_line(pause_line));
	// Free-running 250 MHz clock.
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Inputs change only at falling edges.
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_sys);
	endtask : cyc
	// Compares one byte or flag.
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp) begin
			fails++;
			$display("mismatch %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Host write; strobes stay five cycles, above the three the synchronisers need.
	task automatic wr(input logic cd, input logic [7:0] d);
		host_ctrl.cs_n = cs_val;
		host_ctrl.cd = cd;
		host_data = d;
		host_den = 1'b1;
		host_ctrl.wr_n = 1'b0;
		cyc(5);
		host_ctrl.wr_n = 1'b1;
		host_ctrl.cs_n = 1'b1;
		cyc(1);
		host_den = 1'b0;
		cyc(5);
	endtask : wr
	// Host read compared against an expected byte.
	task automatic rdc(input logic cd, input logic [7:0] exp, input string what);
		host_ctrl.cs_n = 1'b0;
		host_ctrl.cd = cd;
		host_ctrl.rd_n = 1'b0;
		cyc(6);
		chk(what, exp, bus);
		host_ctrl.rd_n = 1'b1;
		host_ctrl.cs_n = 1'b1;
		cyc(6);
	endtask : rdc
	// One acknowledge pulse, taken or expected to be ignored.
	task automatic ackc(input logic taken, input logic [7:0] exp);
		host_ctrl.ack_n = 1'b0;
		cyc(6);
		chk("bus_oe", 8'(taken), 8'(dev_oe));
		chk("resp_oe", 8'(taken), 8'(resp_oe));
		if (taken) begin
			chk("ack_byte", exp, bus);
		end
		host_ctrl.ack_n = 1'b1;
		cyc(6);
	endtask : ackc
	// Marks the end of a test.
	task automatic done(input string name);
		$display("test %s finished", name);
	endtask : done
	// Prints counts and verdict, then stops.
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : wrap_up
	// Cuts a hang short; the tests need about 730 cycles.
	initial begin
		#20000;
		fails++;
		$display("mismatch watchdog expected finish seen hang");
		wrap_up();
	end
	// Test sequence.
	initial begin
		host_ctrl = '{cs_n: 1'b1, rd_n: 1'b1, wr_n: 1'b1, cd: 1'b0, ack_n: 1'b1};
		host_data = 8'h00;
		host_den = 1'b0;
		request_inputs = 8'h00;
		chain_enable_in = 1'b1;
		other_busy = 1'b0;
		cs_val = 1'b0;
		fails = 0;
		num_checks = 0;
		reset_n = 1'b0;
		cyc(20);
		reset_n = 1'b1;
		cyc(4);
		rdc(1'b1, 8'h00, "status");
		chk("chain_out", 8'h01, 8'(chain_enable_out));
		wr(1'b1, 8'hA1);
		rdc(1'b0, 8'hFF, "mask");
		done("reset");
		wr(1'b1, 8'hF2);
		wr(1'b0, 8'h11);
		wr(1'b0, 8'h22);
		wr(1'b0, 8'h33);
		wr(1'b1, 8'hE0);
		wr(1'b0, 8'h5A);
		wr(1'b1, 8'h98);
		rdc(1'b0, 8'hFF, "mask");
		wr(1'b1, 8'h70);
		rdc(1'b0, 8'h00, "mask");
		wr(1'b1, 8'hA0);
		wr(1'b1, 8'hA9);
		rdc(1'b0, 8'h00, "pending");
		done("program");
		request_inputs = 8'h04;
		cyc(8);
		rdc(1'b0, 8'h04, "pending");
		chk("group_int", 8'h01, 8'(grp_out));
		chk("chain_out", 8'h00, 8'(chain_enable_out));
		rdc(1'b1, 8'h8A, "status");
		rdc(1'b1, 8'h8A, "status");
		request_inputs = 8'h00;
		cyc(8);
		rdc(1'b0, 8'h04, "pending");
		ackc(1'b1, 8'h11);
		ackc(1'b1, 8'h22);
		ackc(1'b1, 8'h33);
		chk("resp_oe", 8'h00, 8'(resp_oe));
		rdc(1'b0, 8'h00, "pending");
		wr(1'b1, 8'hA8);
		rdc(1'b0, 8'h04, "in_service");
		wr(1'b1, 8'h42);
		rdc(1'b0, 8'h00, "in_service");
		done("acknowledge");
		wr(1'b1, 8'hC1);
		wr(1'b0, 8'h01);
		wr(1'b1, 8'hA1);
		wr(1'b1, 8'hA9);
		rdc(1'b0, 8'h01, "auto_clear");
		wr(1'b1, 8'h28);
		chain_enable_in = 1'b0;
		cyc(8);
		chk("chain_out", 8'h00, 8'(chain_enable_out));
		ackc(1'b0, 8'h00);
		chain_enable_in = 1'b1;
		other_busy = 1'b1;
		cyc(4);
		ackc(1'b0, 8'h00);
		other_busy = 1'b0;
		cyc(4);
		ackc(1'b1, 8'h5A);
		wr(1'b1, 8'hA0);
		wr(1'b1, 8'hA8);
		rdc(1'b0, 8'h00, "in_service");
		done("auto_clear");
		wr(1'b1, 8'h68);
		wr(1'b1, 8'h28);
		cyc(8);
		chk("group_int", 8'h00, 8'(grp_out));
		cs_val = 1'b1;
		wr(1'b1, 8'h60);
		cs_val = 1'b0;
		chk("group_int", 8'h00, 8'(grp_out));
		wr(1'b1, 8'h60);
		cyc(8);
		chk("group_int", 8'h01, 8'(grp_out));
		wr(1'b1, 8'hB1);
		cyc(8);
		chk("group_int", 8'h00, 8'(grp_out));
		chk("chain_out", 8'h00, 8'(chain_enable_out));
		wr(1'b1, 8'hB0);
		cyc(8);
		chk("group_int", 8'h01, 8'(grp_out));
		done("mask");
		wr(1'b1, 8'h00);
		rdc(1'b1, 8'h00, "status");
		chk("group_int_oe", 8'h00, 8'(grp_oe));
		wr(1'b1, 8'hA1);
		rdc(1'b0, 8'hFF, "mask");
		wr(1'b1, 8'h70);
		wr(1'b1, 8'h2A);
		cyc(8);
		chk("group_int_oe", 8'h01, 8'(grp_oe));
		ackc(1'b1, 8'h11);
		ackc(1'b1, 8'h22);
		ackc(1'b1, 8'h33);
		done("reset_command");
		wrap_up();
	end
endmodule : cascadable_vectored_interrupt_controller_tb_top
